/* rtl/multi_port_timestamp_capture.sv */
// Timestamp capture control and status for four receive ports
// How it works
// - Frame sync edge bit 0 picks rising edge, 1 picks falling edge.
// - Two-bit tick period select: 40 ns, 80 ns, 160 ns or 1.0 us.
// - Early-ready bit set: ready rises once all enabled ports have stamps.
// - Free-running bit 0 restarts stamps at frame sync; 1 runs freely.
// - Capture point bit 0 stamps at a line start, 1 at frame start.
// - Setting hold stops result updates and clears the ready flag.
// - Four per-port enables; only enabled ports capture; all reset disabled.
// - Line-start mode stamps at the line given by upper and lower bytes.
// - Frame-start free-running mode arms at trigger line, stamps next frame.
// - Read-only ready flag shows results readable; hold clears it.
// - Read-only per-port valid flag shows that port holds a fresh stamp.
// - Each port result reads as an upper byte and a lower byte.
`timescale 1ns/1ps
module multi_port_timestamp_capture (
    // Clock and reset
    input  wire logic                                ref_clk_in,
    input  wire logic                                rstn_in,
    // Register port
    input  wire logic [7:0]                          reg_addr_in,
    input  wire logic                                reg_write_in,
    input  wire logic [7:0]                          reg_wdata_in,
    input  wire logic                                reg_read_in,
    output logic      [7:0]                          reg_rdata_out,
    // Frame sync pin
    input  wire logic                                frame_sync_in,
    // Receive port markers, one-cycle pulses
    input  wire logic [stamp_pkg::NUM_PORTS-1:0]     line_start_in,
    input  wire logic [stamp_pkg::NUM_PORTS-1:0]     frame_start_in,
    // Status
    output logic                                     captures_ready_out,
    output logic      [stamp_pkg::NUM_PORTS-1:0]     capture_valid_out
);
    import stamp_pkg::*;

    typedef struct packed {
        logic [7:0]           config_bits;
        logic [7:0]           control;
        logic [7:0]           line_upper;
        logic [7:0]           line_lower;
        logic                 ready;
        logic                 pending;
        logic [NUM_PORTS-1:0] valid;
        logic [2:0]           sync_pipe;
        logic [7:0]           rdata;
    } top_state_s;

    top_state_s state_reg;
    top_state_s state_next;

    logic [STAMP_W-1:0]   stamp;
    logic [NUM_PORTS-1:0] capture;
    logic [STAMP_W-1:0]   result [NUM_PORTS];
    logic                 edge_select;
    logic                 free_running;
    logic                 hold;
    logic                 sync_event;
    logic                 restart;
    logic [NUM_PORTS-1:0] enables;
    logic [NUM_PORTS-1:0] valid_now;
    logic                 all_valid;
    logic [7:0]           status_byte;
    logic [7:0]           result_index;
    logic [STAMP_W-1:0]   result_sel;

    assign edge_select  = state_reg.config_bits[CFG_EDGE_BIT];
    assign free_running = state_reg.config_bits[CFG_FREE_BIT];
    assign hold         = state_reg.control[CTL_HOLD_BIT];
    assign enables      = state_reg.control[NUM_PORTS-1:0];

    // Edge detect looks only at the second and third sync stages
    always_comb begin
        if (edge_select) begin
            sync_event = state_reg.sync_pipe[2] && !state_reg.sync_pipe[1];
        end else begin
            sync_event = !state_reg.sync_pipe[2] && state_reg.sync_pipe[1];
        end
    end

    assign restart = sync_event && !free_running;

    stamp_tick_gen u_tick (
        .ref_clk_in            (ref_clk_in),
        .rstn_in               (rstn_in),
        .tick_period_select_in (state_reg.config_bits[CFG_TICK_LSB +: 2]),
        .restart_in            (restart),
        .stamp_out             (stamp)
    );

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        stamp_port_capture u_port (
            .ref_clk_in      (ref_clk_in),
            .rstn_in         (rstn_in),
            .line_start_in   (line_start_in[p]),
            .frame_start_in  (frame_start_in[p]),
            .enable_in       (enables[p]),
            .hold_in         (hold),
            .free_running_in (free_running),
            .frame_point_in  (state_reg.config_bits[CFG_POINT_BIT]),
            .trigger_line_in ({state_reg.line_upper, state_reg.line_lower}),
            .stamp_in        (stamp),
            .capture_out     (capture[p]),
            .result_out      (result[p])
        );
    end

    always_comb begin
        result_index = reg_addr_in - ADDR_RESULT0;
        result_sel   = result[result_index[2:1]];
    end

    always_comb begin
        state_next           = state_reg;
        state_next.sync_pipe = {state_reg.sync_pipe[1:0], frame_sync_in};

        // A new capture round starts at each active sync edge outside hold; a
        // capture landing in that same cycle still sets its flag.
        valid_now = state_reg.valid;
        if (sync_event && !hold) begin
            valid_now = '0;
        end
        valid_now        = valid_now | capture;
        state_next.valid = valid_now;
        all_valid        = (enables != '0)
                           && ((valid_now & enables) == enables);

        if (state_reg.config_bits[CFG_EARLY_BIT] || free_running) begin
            // Free-running stamps do not restart at sync, so it reports early too
            if (all_valid && !hold) begin
                state_next.ready = 1'b1;
            end
        end else begin
            // Normal: full round is declared at the next sync edge
            if (sync_event && !hold) begin
                // Sticky: only a hold write takes ready down again
                if (state_reg.pending) begin
                    state_next.ready = 1'b1;
                end
                state_next.pending = 1'b0;
            end
            if (all_valid && !hold) begin
                state_next.pending = 1'b1;
            end
        end

        if (reg_write_in) begin
            unique case (reg_addr_in)
                ADDR_CONFIG: begin
                    state_next.config_bits = reg_wdata_in & CFG_WR_MASK;
                end
                ADDR_CONTROL: begin
                    state_next.control = reg_wdata_in & CTL_WR_MASK;
                    if (reg_wdata_in[CTL_HOLD_BIT]) begin
                        state_next.ready   = 1'b0;
                        state_next.pending = 1'b0;
                    end else if (hold) begin
                        // Releasing hold opens a fresh round
                        state_next.valid = capture;
                    end
                end
                ADDR_LINE_UP: state_next.line_upper = reg_wdata_in;
                ADDR_LINE_LO: state_next.line_lower = reg_wdata_in;
                default: ;
            endcase
        end

        status_byte = {3'b000, state_reg.ready, state_reg.valid};
        if (reg_read_in) begin
            if (reg_addr_in >= ADDR_RESULT0
                && reg_addr_in <= ADDR_RESULT_END) begin
                if (result_index[0]) begin
                    state_next.rdata = result_sel[7:0];
                end else begin
                    state_next.rdata = result_sel[15:8];
                end
            end else begin
                unique case (reg_addr_in)
                    ADDR_CONFIG:  state_next.rdata = state_reg.config_bits;
                    ADDR_CONTROL: state_next.rdata = state_reg.control;
                    ADDR_LINE_UP: state_next.rdata = state_reg.line_upper;
                    ADDR_LINE_LO: state_next.rdata = state_reg.line_lower;
                    ADDR_STATUS:  state_next.rdata = status_byte;
                    default:      state_next.rdata = RST_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out      = state_reg.rdata;
    assign captures_ready_out = state_reg.ready;
    assign capture_valid_out  = state_reg.valid;
endmodule : multi_port_timestamp_capture

/* shared/stamp_pkg.sv */
// Register map, field positions and timing constants of the stamp block
package stamp_pkg;
    localparam int          NUM_PORTS      = 4;
    localparam int          STAMP_W        = 16;
    // Register offsets
    localparam logic [7:0]  ADDR_CONFIG    = 8'h25;
    localparam logic [7:0]  ADDR_CONTROL   = 8'h26;
    localparam logic [7:0]  ADDR_LINE_UP   = 8'h27;
    localparam logic [7:0]  ADDR_LINE_LO   = 8'h28;
    localparam logic [7:0]  ADDR_STATUS    = 8'h29;
    localparam logic [7:0]  ADDR_RESULT0   = 8'h2A;
    localparam logic [7:0]  ADDR_RESULT_END = 8'h31;
    // Reset values
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [15:0] RST_WORD       = 16'h0000;
    // Field positions in stamp_config
    localparam int          CFG_EDGE_BIT   = 6;
    localparam int          CFG_TICK_LSB   = 4;
    localparam int          CFG_EARLY_BIT  = 3;
    localparam int          CFG_FREE_BIT   = 1;
    localparam int          CFG_POINT_BIT  = 0;
    localparam logic [7:0]  CFG_WR_MASK    = 8'h7B;
    // Field positions in stamp_control and stamp_status
    localparam int          CTL_HOLD_BIT   = 4;
    localparam logic [7:0]  CTL_WR_MASK    = 8'h1F;
    localparam int          STS_READY_BIT  = 4;
    // Tick periods
    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          TICK0_NS       = 40;
    localparam int          TICK1_NS       = 80;
    localparam int          TICK2_NS       = 160;
    localparam int          TICK3_NS       = 1000;
    localparam logic [7:0]  TICK0_CYC = 8'((TICK0_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS);
    localparam logic [7:0]  TICK1_CYC = 8'((TICK1_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS);
    localparam logic [7:0]  TICK2_CYC = 8'((TICK2_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS);
    localparam logic [7:0]  TICK3_CYC = 8'((TICK3_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS);
endpackage : stamp_pkg

/* rtl/stamp_tick_gen.sv */
// Tick divider and timestamp counter shared by all receive ports
`timescale 1ns/1ps
module stamp_tick_gen (
    // Clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          rstn_in,
    // Control
    input  wire logic [1:0]                    tick_period_select_in,
    input  wire logic                          restart_in,
    // Counter
    output logic      [stamp_pkg::STAMP_W-1:0] stamp_out
);
    import stamp_pkg::*;

    typedef struct packed {
        logic [7:0]         div;
        logic [STAMP_W-1:0] stamp;
    } tick_state_s;

    tick_state_s state_reg;
    tick_state_s state_next;
    logic [7:0]  period;

    always_comb begin
        unique case (tick_period_select_in)
            2'b00: period = TICK0_CYC;
            2'b01: period = TICK1_CYC;
            2'b10: period = TICK2_CYC;
            2'b11: period = TICK3_CYC;
        endcase
        state_next = state_reg;
        if (restart_in) begin
            state_next.div   = RST_BYTE;
            state_next.stamp = RST_WORD;
        end else if (state_reg.div >= period - 8'h01) begin
            state_next.div   = RST_BYTE;
            state_next.stamp = state_reg.stamp + 16'h0001;
        end else begin
            state_next.div = state_reg.div + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign stamp_out = state_reg.stamp;
endmodule : stamp_tick_gen

/* rtl/stamp_port_capture.sv */
// Per-port line counting and capture of the timestamp counter
`timescale 1ns/1ps
module stamp_port_capture (
    // Clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          rstn_in,
    // Receive port markers
    input  wire logic                          line_start_in,
    input  wire logic                          frame_start_in,
    // Configuration
    input  wire logic                          enable_in,
    input  wire logic                          hold_in,
    input  wire logic                          free_running_in,
    input  wire logic                          frame_point_in,
    input  wire logic [15:0]                   trigger_line_in,
    input  wire logic [stamp_pkg::STAMP_W-1:0] stamp_in,
    // Result
    output logic                               capture_out,
    output logic      [stamp_pkg::STAMP_W-1:0] result_out
);
    import stamp_pkg::*;

    typedef struct packed {
        logic [15:0]        line;
        logic               armed;
        logic               done;
        logic               capture;
        logic [STAMP_W-1:0] result;
    } port_state_s;

    port_state_s state_reg;
    port_state_s state_next;
    logic [15:0] line_inc;
    logic        hit;

    always_comb begin
        state_next         = state_reg;
        state_next.capture = 1'b0;
        line_inc           = state_reg.line + 16'h0001;
        hit                = 1'b0;
        if (frame_start_in) begin
            state_next.line = RST_WORD;
            state_next.done = 1'b0;
        end else if (line_start_in) begin
            state_next.line = line_inc;
        end
        if (frame_point_in) begin
            if (free_running_in) begin
                // Arm at the line start of the trigger line, stamp the next frame
                if (line_start_in && line_inc == trigger_line_in) begin
                    state_next.armed = 1'b1;
                end
                hit = frame_start_in && state_reg.armed;
                if (hit) begin
                    state_next.armed = 1'b0;
                end
            end else begin
                hit = frame_start_in;
            end
        end else begin
            hit = line_start_in && !frame_start_in && !state_reg.done
                  && line_inc == trigger_line_in;
            if (hit) begin
                state_next.done = 1'b1;
            end
        end
        if (hit && enable_in && !hold_in) begin
            state_next.result  = stamp_in;
            state_next.capture = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign capture_out = state_reg.capture;
    assign result_out  = state_reg.result;
endmodule : stamp_port_capture

/* test/stamp_rx_model.sv */
// Receive-side model: frame sync pin and per-port line and frame markers
`timescale 1ns/1ps
module stamp_rx_model (
    // Clock
    input  wire logic       ref_clk_in,
    // Towards the block
    output logic            frame_sync_out,
    output logic [3:0]      line_start_out,
    output logic [3:0]      frame_start_out
);
    initial begin
        frame_sync_out = 1'b0;
        line_start_out = 4'h0;
        frame_start_out = 4'h0;
    end
    // Settle at the idle level first so only one active edge is made
    task automatic sync_edge(input logic fall);
        frame_sync_out = fall;
        repeat (6) @(posedge ref_clk_in);
        #1;
        frame_sync_out = ~fall;
    endtask : sync_edge
    // One-cycle markers, then a quiet cycle before the next pair
    task automatic pulse(input logic [3:0] fs, input logic [3:0] ls);
        frame_start_out = fs;
        line_start_out = ls;
        @(posedge ref_clk_in);
        #1;
        frame_start_out = 4'h0;
        line_start_out = 4'h0;
        @(posedge ref_clk_in);
        #1;
    endtask : pulse
endmodule : stamp_rx_model

/* test/stamp_chk.sv */
// Assertions on the register port and status outputs of the stamp block
`timescale 1ns/1ps
module stamp_chk
    import stamp_pkg::*;
(
    input wire logic                            ref_clk_in,
    input wire logic                            rstn_in,
    input wire logic [7:0]                      reg_addr_in,
    input wire logic                            reg_write_in,
    input wire logic [7:0]                      reg_wdata_in,
    input wire logic                            reg_read_in,
    input wire logic [7:0]                      reg_rdata_out,
    input wire logic                            frame_sync_in,
    input wire logic [stamp_pkg::NUM_PORTS-1:0] line_start_in,
    input wire logic [stamp_pkg::NUM_PORTS-1:0] frame_start_in,
    input wire logic                            captures_ready_out,
    input wire logic [stamp_pkg::NUM_PORTS-1:0] capture_valid_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire hold_wr = reg_write_in && reg_addr_in == ADDR_CONTROL
                   && reg_wdata_in[CTL_HOLD_BIT];
    wire cfg_wr = reg_write_in && reg_addr_in == ADDR_CONFIG;
    wire cfg_rd = reg_read_in && reg_addr_in == ADDR_CONFIG;
    wire [NUM_PORTS-1:0] marker = line_start_in | frame_start_in;
    hold_clears_ready_a: assert property (
        hold_wr |=> !captures_ready_out) else $error("ready kept over hold");
    ready_sticky_a: assert property (
        captures_ready_out && !hold_wr |=> captures_ready_out)
        else $error("ready dropped without hold");
    status_read_a: assert property (
        reg_read_in && reg_addr_in == ADDR_STATUS |=> reg_rdata_out ==
        {3'b000, $past(captures_ready_out), $past(capture_valid_out)})
        else $error("status read differs from flags");
    unmapped_zero_a: assert property (
        reg_read_in && (reg_addr_in < ADDR_CONFIG
        || reg_addr_in > ADDR_RESULT_END) |=> reg_rdata_out == RST_BYTE)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        !reg_read_in |=> $stable(reg_rdata_out))
        else $error("read data moved without read");
    cfg_readback_a: assert property (
        cfg_wr ##1 !reg_write_in ##1 cfg_rd
        |=> reg_rdata_out == ($past(reg_wdata_in, 3) & CFG_WR_MASK))
        else $error("config readback wrong");
    valid_cause_a: assert property (
        (capture_valid_out & ~$past(capture_valid_out)
        & ~$past(marker, 2)) == 4'h0)
        else $error("valid rose without marker");
    // Early mode raises ready on the very edge that sets valid
    ready_cause_a: assert property (
        $rose(captures_ready_out) |-> ($past(capture_valid_out) != 4'h0
        || capture_valid_out != 4'h0))
        else $error("ready rose with no valid port");
    cover property (hold_wr && captures_ready_out);
    cover property ($rose(capture_valid_out[1]));
    cover property ($rose(captures_ready_out) && capture_valid_out == 4'h0);
endmodule : stamp_chk

bind multi_port_timestamp_capture stamp_chk chk (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .frame_sync_in(frame_sync_in), .line_start_in(line_start_in),
    .frame_start_in(frame_start_in),
    .captures_ready_out(captures_ready_out),
    .capture_valid_out(capture_valid_out));

/* test/test_multi_port_timestamp_capture.sv */
// Self-checking bench for the four-port timestamp capture block
`timescale 1ns/1ps
module test_multi_port_timestamp_capture;
    import stamp_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic        reg_write_in = 1'b0;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        reg_read_in = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        fsync;
    logic [3:0]  lstart;
    logic [3:0]  fstart;
    logic        captures_ready_out;
    logic [3:0]  capture_valid_out;
    logic [15:0] note_q[$];
    logic [15:0] note;
    logic        rd_seen = 1'b0;
    logic [31:0] seed = 32'h0000_5db0;
    int          err_total = 0;
    int          comparisons = 0;
    always #10 ref_clk_in = ~ref_clk_in;
    stamp_rx_model rx (.ref_clk_in(ref_clk_in), .frame_sync_out(fsync),
        .line_start_out(lstart), .frame_start_out(fstart));
    multi_port_timestamp_capture uut (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .frame_sync_in(fsync), .line_start_in(lstart),
        .frame_start_in(fstart), .captures_ready_out(captures_ready_out),
        .capture_valid_out(capture_valid_out));
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xorshift
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_write_in = 1'b1;
        idle(1);
        reg_write_in = 1'b0;
        idle(1);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        note_q.push_back({a, e});
        reg_addr_in = a;
        reg_read_in = 1'b1;
        idle(1);
        reg_read_in = 1'b0;
        idle(1);
    endtask : rd
    task automatic cmp(input logic [7:0] a, e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("mismatch reg %h expected %h seen %h", a, e, g);
        end
    endtask : cmp
    task automatic cmp_flags(input logic [4:0] e);
        comparisons++;
        if ({captures_ready_out, capture_valid_out} !== e) begin
            err_total++;
            $display("mismatch flags expected %h seen %h", e,
                     {captures_ready_out, capture_valid_out});
        end
    endtask : cmp_flags
    always @(posedge ref_clk_in) rd_seen <= reg_read_in;
    always @(negedge ref_clk_in) begin
        if (rd_seen) begin
            note = note_q.pop_front();
            cmp(note[15:8], note[7:0], reg_rdata_out);
            // Status reads are taken while the flags stand still
            if (note[15:8] == ADDR_STATUS) begin
                cmp_flags(note[4:0]);
            end
        end
    end
    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Whole run is near 1060 cycles; about nineteen times that means a hang
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_total++;
        tally_and_finish();
    end
    initial begin : main
        int per[4];
        int m;
        logic [7:0] adr[4];
        logic [7:0] msk[4];
        per = '{int'(TICK0_CYC), int'(TICK1_CYC), int'(TICK2_CYC),
                int'(TICK3_CYC)};
        adr = '{ADDR_CONFIG, ADDR_CONTROL, ADDR_LINE_UP, ADDR_LINE_LO};
        msk = '{CFG_WR_MASK, CTL_WR_MASK, 8'hFF, 8'hFF};
        idle(10);
        rstn_in = 1'b1;
        for (int a = 8'h24; a <= 8'h32; a++) begin
            rd(8'(a), 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            wr(adr[i % 4], seed[7:0]);
            rd(adr[i % 4], seed[7:0] & msk[i % 4]);
        end
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, 8'h00);
        // Each tick code once, rising edge on even codes, falling on odd, early ready, frame point
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_CONFIG, 8'(t % 2 * 8'h40 + t * 8'h10 + 8'h09));
            wr(ADDR_CONTROL, 8'h01);
            rx.sync_edge(t % 2 == 1);
            m = 3 + 3 * per[t] + (per[t] - 1) / 2;
            idle(m);
            rx.pulse(4'h1, 4'h0);
            idle(4);
            rd(ADDR_STATUS, 8'h11);
            wr(ADDR_CONTROL, 8'h11);
            rd(ADDR_STATUS, 8'h01);
            rx.pulse(4'h1, 4'h0);
            idle(4);
            rd(ADDR_RESULT0, 8'h00);
            rd(ADDR_RESULT0 + 8'h01, 8'h03);
            wr(ADDR_CONTROL, 8'h01);
            rd(ADDR_STATUS, 8'h00);
        end
        wr(ADDR_CONFIG, 8'h03);
        wr(ADDR_LINE_UP, 8'h00);
        wr(ADDR_LINE_LO, 8'h02);
        rx.pulse(4'h1, 4'h0);
        rx.pulse(4'h0, 4'h1);
        rx.pulse(4'h1, 4'h0);
        idle(4);
        rd(ADDR_STATUS, 8'h00);
        rx.pulse(4'h0, 4'h1);
        rx.pulse(4'h0, 4'h1);
        rx.pulse(4'h1, 4'h0);
        idle(4);
        rd(ADDR_STATUS, 8'h11);
        // Line 258 lands mid-period of the 1 us tick: stamp 10
        wr(ADDR_CONFIG, 8'h30);
        wr(ADDR_LINE_UP, 8'h01);
        wr(ADDR_LINE_LO, 8'h02);
        wr(ADDR_CONTROL, 8'h16);
        wr(ADDR_CONTROL, 8'h06);
        rx.sync_edge(1'b0);
        idle(12);
        rx.pulse(4'hF, 4'h0);
        repeat (258) rx.pulse(4'h0, 4'hF);
        idle(4);
        rd(ADDR_STATUS, 8'h06);
        rx.sync_edge(1'b0);
        idle(6);
        rd(ADDR_STATUS, 8'h10);
        wr(ADDR_CONTROL, 8'h16);
        for (int p = 1; p < 4; p++) begin
            rd(8'(ADDR_RESULT0 + 2 * p), 8'h00);
            rd(8'(ADDR_RESULT0 + 2 * p + 1), p == 3 ? 8'h00 : 8'h0A);
        end
        tally_and_finish();
    end
endmodule : test_multi_port_timestamp_capture
